// ==== core/sra_defines.svh ====
// Constants for the serial register access and limit alert block.
// Assumes inclusion by bare name from any design or bench file.
`ifndef SRA_DEFINES_SVH
`define SRA_DEFINES_SVH
`define SRA_CMD_WRITE        8'h90
`define SRA_CMD_READ         8'h91
`define SRA_PTR_LAST         6'h3F
`define SRA_PTR_FIRST        6'h00
`define SRA_REG_CTRL         6'h18
`define SRA_REG_STAT1        6'h00
`define SRA_REG_STAT2        6'h01
`define SRA_CTRL_RESET       8'h00
`define SRA_BIT_POLARITY     6
`define SRA_BIT_DISABLE      5
`define SRA_ARA_ADDR         7'h0C
`define SRA_CS_PULSES_LOCK   2'h3
`endif

// ==== core/sra_pkg.sv ====
// Types shared by the serial register access block and its bench.
// Assumes sra_defines.svh is on the include path.
package sra_pkg;
  typedef enum logic [1:0] {SRA_CMD, SRA_ADDR, SRA_WDATA, SRA_RDATA} sra_phase_e;
  // Limit comparison flags from one conversion
  typedef struct packed {
    logic int_high;
    logic int_low;
    logic ext_high;
    logic ext_low;
    logic sup_high;
    logic sup_low;
  } sra_limits_s;
endpackage

// ==== core/sra_spi_regs.sv ====
// Serial slave register access with limit alert output.
// Assumes serial pins are asynchronous to ref_clk, link clock well below ref_clk/4.
// Notes on behaviour
// R1 - First byte is command: 0x90 write, 0x91 read; others ignored.
// R2 - Input bits are sampled at serial clock rising edges.
// R3 - With select high, input and output lines are left undriven.
// R4 - Input is ignored until select falls; data taken only afterwards.
// R5 - Write: byte after command loads pointer; later bytes stored at pointer.
// R6 - Pointer advances after each written byte, wrapping 0x3F to 0x00.
// R7 - Host loads pointer with a write before a separate read.
// R8 - During the read command byte the output carries meaningless values.
// R9 - Next eight clocks shift out the register selected by pointer.
// R10 - Output bit changes on each serial clock falling edge.
// R11 - Continued read clocking advances pointer, outputs successive registers, wrapping.
// R12 - Alert goes active on any limit event unless that event is disabled.
// R13 - Control bit 6 at 0x18 picks alert polarity; default active low.
// R14 - Control bit 5 at 0x18 disables alert when one; in active high the code releases the line, showing alert.
// R15 - Alert when internal, external or supply value exceeds its upper/lower limit.
// R16 - Alert clears only when all in limits and the status was read.
// R17 - Two status registers show which limit event caused the alert.
// R18 - Alert output is open drain for sharing; sharing needs active low.
// R19 - With two-wire bus selected, alert acts as bus alert signal.
// R20 - Master reads alert response address; devices holding alert answer it.
// R21 - Answer is own seven-bit address with a one appended.
// R22 - Lowest bus address wins arbitration in the alert response.
// R23 - Master repeats alert response read while the line stays low.
// R24 - Four-wire interface locks on third rising edge of select.
// R25 - Select high ends the transaction; pointer is kept.
`include "sra_defines.svh"
module sra_spi_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h48  // Arbitrary neutral bus address
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Serial pins
  input  wire logic                cs_n_pin,
  input  wire logic                sclk_pin,
  input  wire logic                din_pin,
  output logic                     din_oe,
  output logic                     dout_out,
  output logic                     dout_oe,
  // Limit results from the converter side
  input  wire sra_pkg::sra_limits_s limits,
  input  wire logic                conv_done,
  input  wire logic [5:0]          limit_mask,
  // Alert response from the two-wire side
  input  wire logic                ara_ack,
  output logic [7:0]               ara_byte,
  // Alert pin, open drain
  output logic                     alert_out,
  output logic                     alert_oe,
  // Status
  output logic                     spi_locked
);
  import sra_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sync1_reg, sync1_next;
  logic [2:0] sync2_reg, sync2_next;
  logic [2:0] prev_reg, prev_next;

  // Three flops per pin; logic reads sync2, and prev for edge detection
  always_comb begin
    sync1_next = {cs_n_pin, sclk_pin, din_pin};
    sync2_next = sync1_reg;
    prev_next  = sync2_reg;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sync1_reg <= 3'h7;
      sync2_reg <= 3'h7;
      prev_reg  <= 3'h7;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  logic cs_n, sclk, din, sclk_rise, sclk_fall, cs_fall, cs_rise;
  assign cs_n      = sync2_reg[2];
  assign sclk      = sync2_reg[1];
  assign din       = sync2_reg[0];
  assign sclk_rise = sclk & ~prev_reg[1];  // R2
  assign sclk_fall = ~sclk & prev_reg[1];  // R10
  assign cs_fall   = ~cs_n & prev_reg[2];  // R4
  assign cs_rise   = cs_n & ~prev_reg[2];

  // ----------------------------------------
  // Register file and serial engine
  // ----------------------------------------
  logic [7:0] regs_mem [0:63];
  logic [7:0] ctrl_reg, ctrl_next;
  logic [5:0] ptr_reg, ptr_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic [2:0] bit_reg, bit_next;
  sra_phase_e phase_reg, phase_next;
  logic       active_reg, active_next;
  logic       bad_reg, bad_next;
  logic       dout_reg, dout_next;
  logic [1:0] cs_cnt_reg, cs_cnt_next;
  logic       lock_reg, lock_next;
  logic       wr_en;
  logic       rd_stat;
  logic [7:0] rx_byte;
  logic [5:0] stat_reg, stat_next;

  // Wrapping increment, used by both write and read paths
  function automatic logic [5:0] ptr_inc(input logic [5:0] p);
    ptr_inc = (p == `SRA_PTR_LAST) ? `SRA_PTR_FIRST : p + 6'h01;  // R6 R11
  endfunction

  // Readback mux; status and control are live, the rest come from the array
  function automatic logic [7:0] rd_val(input logic [5:0] p, input logic [7:0] c,
                                        input logic [5:0] s, input logic [7:0] m);
    case (p)
      `SRA_REG_STAT1: rd_val = {4'h0, s[5:2]};   // R17
      `SRA_REG_STAT2: rd_val = {6'h00, s[1:0]};  // R17
      `SRA_REG_CTRL:  rd_val = c;
      default:        rd_val = m;
    endcase
  endfunction

  assign rx_byte = {shift_reg[6:0], din};

  always_comb begin
    ctrl_next   = ctrl_reg;
    ptr_next    = ptr_reg;
    shift_next  = shift_reg;
    tx_next     = tx_reg;
    bit_next    = bit_reg;
    phase_next  = phase_reg;
    active_next = active_reg;
    bad_next    = bad_reg;
    dout_next   = dout_reg;
    cs_cnt_next = cs_cnt_reg;
    lock_next   = lock_reg;
    wr_en       = 1'b0;
    rd_stat     = 1'b0;
    // Count select pulses until the four-wire mode locks
    if (cs_rise && !lock_reg) begin
      cs_cnt_next = cs_cnt_reg + 2'h1;
      if (cs_cnt_next == `SRA_CS_PULSES_LOCK) lock_next = 1'b1;  // R24
    end
    if (cs_n) begin
      active_next = 1'b0;  // R25
    end else if (cs_fall) begin
      active_next = 1'b1;  // R4
      phase_next  = SRA_CMD;
      bit_next    = 3'h0;
      bad_next    = 1'b0;
    end else if (active_reg && lock_reg && !bad_reg && sclk_rise) begin
      shift_next = rx_byte;  // R2
      bit_next   = bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        case (phase_reg)
          SRA_CMD: begin
            if (rx_byte == `SRA_CMD_WRITE) phase_next = SRA_ADDR;  // R1
            else if (rx_byte == `SRA_CMD_READ) begin
              phase_next = SRA_RDATA;  // R1 R9
              tx_next    = rd_val(ptr_reg, ctrl_reg, stat_reg, regs_mem[ptr_reg]);
              rd_stat    = (ptr_reg == `SRA_REG_STAT1) || (ptr_reg == `SRA_REG_STAT2);
            end else bad_next = 1'b1;  // Unknown command: rest of frame ignored
          end
          SRA_ADDR: begin
            ptr_next   = rx_byte[5:0];  // R5
            phase_next = SRA_WDATA;
          end
          SRA_WDATA: begin
            wr_en    = 1'b1;  // R5
            if (ptr_reg == `SRA_REG_CTRL) ctrl_next = rx_byte;
            ptr_next = ptr_inc(ptr_reg);  // R6
          end
          SRA_RDATA: begin
            ptr_next = ptr_inc(ptr_reg);  // R11
            tx_next  = rd_val(ptr_next, ctrl_reg, stat_reg, regs_mem[ptr_next]);
            rd_stat  = (ptr_next == `SRA_REG_STAT1) || (ptr_next == `SRA_REG_STAT2);
          end
          default: phase_next = SRA_CMD;
        endcase
      end
    end else if (active_reg && sclk_fall) begin
      // Command byte output is don't-care; data shifts MSB first
      if (phase_reg == SRA_RDATA) begin
        dout_next = tx_reg[7];  // R9 R10
        tx_next   = {tx_reg[6:0], 1'b0};
      end else dout_next = 1'b0;  // R8
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_reg   <= `SRA_CTRL_RESET;  // R13
      ptr_reg    <= `SRA_PTR_FIRST;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      bit_reg    <= 3'h0;
      phase_reg  <= SRA_CMD;
      active_reg <= 1'b0;
      bad_reg    <= 1'b0;
      dout_reg   <= 1'b0;
      cs_cnt_reg <= 2'h0;
      lock_reg   <= 1'b0;
    end else begin
      ctrl_reg   <= ctrl_next;
      ptr_reg    <= ptr_next;
      shift_reg  <= shift_next;
      tx_reg     <= tx_next;
      bit_reg    <= bit_next;
      phase_reg  <= phase_next;
      active_reg <= active_next;
      bad_reg    <= bad_next;
      dout_reg   <= dout_next;
      cs_cnt_reg <= cs_cnt_next;
      lock_reg   <= lock_next;
    end
  end

  // Array has no reset; it stands for limit and DAC storage
  always_ff @(posedge ref_clk) begin
    if (wr_en) regs_mem[ptr_reg] <= rx_byte;  // R5
  end

  // ----------------------------------------
  // Limit status and alert
  // ----------------------------------------
  logic       read_seen_reg, read_seen_next;
  logic       alert_reg, alert_next;
  logic       drive_reg, drive_next;
  logic       in_limits;
  logic [5:0] events;

  assign events    = limits & ~limit_mask;  // R12 R15
  assign in_limits = ~|limits;

  // Sticky status: a new event wins over a clear on read
  always_comb begin
    stat_next      = stat_reg;
    read_seen_next = read_seen_reg;
    alert_next     = alert_reg;
    if (rd_stat) read_seen_next = 1'b1;
    if (conv_done && in_limits && (read_seen_reg || rd_stat)) begin
      stat_next      = 6'h00;  // R16
      alert_next     = 1'b0;   // R16
      read_seen_next = 1'b0;
    end
    if (conv_done && |events) begin
      stat_next      = stat_reg | events;  // R17
      alert_next     = 1'b1;               // R12 R15
      read_seen_next = 1'b0;
    end
    // The answered response does not itself release the line
    drive_next = alert_reg & ~ctrl_reg[`SRA_BIT_DISABLE];  // R14
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stat_reg      <= 6'h00;
      read_seen_reg <= 1'b0;
      alert_reg     <= 1'b0;
      drive_reg     <= 1'b0;
    end else begin
      stat_reg      <= stat_next;
      read_seen_reg <= read_seen_next;
      alert_reg     <= alert_next;
      drive_reg     <= drive_next;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic ara_hit;

  // Only a device with its alert still asserted and not disabled answers the response read
  assign ara_hit = ara_ack & drive_reg;  // R20

  // Unless disabled, active low pulls while alerting; active high pulls while quiet and leaves the alert to the pull-up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      alert_out <= 1'b0;
      alert_oe  <= 1'b0;
      dout_out  <= 1'b0;
      dout_oe   <= 1'b0;
      din_oe    <= 1'b0;  // R3
      ara_byte  <= 8'hFF;
    end else begin
      alert_out <= 1'b0;  // R18
      alert_oe  <= ctrl_reg[`SRA_BIT_POLARITY] ? (~drive_next & ~ctrl_reg[`SRA_BIT_DISABLE])
                                               : drive_next;  // R13 R18 R19
      dout_out  <= dout_reg;
      dout_oe   <= active_reg & ~cs_n & (phase_reg == SRA_RDATA);  // R3
      din_oe    <= 1'b0;  // R3
      // Released bits read as ones, so on a shared bus the lowest address wins
      ara_byte  <= ara_hit ? {DEV_ADDR, 1'b1} : 8'hFF;  // R21 R22
    end
  end
  assign spi_locked = lock_reg;
endmodule

// ==== dv/sra_spi_regs_properties.sv ====
// Checker for the serial register block, watching its top ports only.
// Assumes one ref_clk domain with a synchronous active-low reset.
module sra_spi_regs_check #(
  parameter logic [6:0] DEV_ADDR = 7'h48  // Arbitrary bus address
) (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Serial pins
  input wire logic       cs_n_pin,
  input wire logic       sclk_pin,
  input wire logic       din_oe,
  input wire logic       dout_out,
  input wire logic       dout_oe,
  // Alert side and serial lock status
  input wire logic       ara_ack,
  input wire logic [7:0] ara_byte,
  input wire logic       alert_out,
  input wire logic       spi_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // --------------------
  // Select rise counting
  // --------------------
  logic       cs_reg;
  logic [1:0] rises_reg;
  logic [1:0] rises_next;
  // Raw pin rises lead the synced view, so the count is never late
  always_comb begin
    rises_next = rises_reg;
    if (cs_n_pin && !cs_reg && rises_reg != 2'h3) begin
      rises_next = rises_reg + 2'h1;
    end
    if (!rst_n) begin
      rises_next = 2'h0;
    end
  end
  // Registers only
  always_ff @(posedge ref_clk) begin
    cs_reg    <= cs_n_pin;
    rises_reg <= rises_next;
  end
  // ----------
  // Properties
  // ----------
  din_undriven_a: assert property (!din_oe) else $error("din driven");
  dout_idle_a: assert property (cs_n_pin [*5] |-> !dout_oe) else $error("dout driven unselected");
  cmd_quiet_a: assert property ($fell(cs_n_pin) |=> !dout_oe [*8]) else $error("dout in command");
  dout_edge_a: assert property (dout_oe && !cs_n_pin && $changed(dout_out)
    |-> !$past(sclk_pin, 2) || !$past(sclk_pin, 3)) else $error("dout moved off falling edge");
  lock_hold_a: assert property (!$fell(spi_locked)) else $error("lock lost");
  lock_count_a: assert property (spi_locked |-> rises_reg == 2'h3) else $error("early lock");
  ara_value_a: assert property (ara_byte != 8'hFF |-> ara_byte == {DEV_ADDR, 1'b1})
    else $error("bad alert answer");
  ara_quiet_a: assert property (!$past(ara_ack) |-> ara_byte == 8'hFF) else $error("unasked answer");
  alert_drain_a: assert property (!alert_out) else $error("alert driven high");
endmodule

bind sra_spi_regs sra_spi_regs_check #(.DEV_ADDR(DEV_ADDR)) u_check (.ref_clk, .rst_n, .cs_n_pin,
  .sclk_pin, .din_oe, .dout_out, .dout_oe, .ara_ack, .ara_byte, .alert_out, .spi_locked);

// ==== dv/sra_host.sv ====
// Serial host model: drives select, clock and data, samples the reply.
// Assumes the bench adds pull-ups on released lines.
module sra_host (
  // Serial lines
  output logic     cs_n,
  output logic     sclk,
  output logic     din,
  input wire logic dout_w
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock idles high and stands still outside frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b1;
  end
  // One frame of n bytes, MSB first, left aligned in tx and rx
  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx   = 32'h0;
    cs_n = 1'b0;
    #400;
    for (int i = 31; i >= 32 - 8 * n; i--) begin
      sclk = 1'b0;
      din  = tx[i];
      #200 sclk = 1'b1;
      // Late sample leaves the slow synced output time to settle
      #190 rx[i] = dout_w;
      #10;
    end
    #400 cs_n = 1'b1;
    #400;
  endtask
endmodule

// ==== dv/sra_spi_regs_test.sv ====
// Self-checking bench for the serial register block.
// Assumes the host model and the bound checker are compiled alongside.
`include "sra_defines.svh"
module sra_spi_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sra_pkg::*;
  localparam logic [6:0] BUS_ADDR = 7'h2B;  // Arbitrary value
  // ----------------
  // Signals and DUT
  // ----------------
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cs_n, sclk, h_din, din_oe, dout_out, dout_oe;
  logic        conv_done, ara_ack, alert_out, alert_oe, spi_locked;
  logic [7:0]  ara_byte;
  logic [5:0]  limit_mask;
  sra_limits_s limits;
  logic [31:0] rx;
  int          n_fail = 0;
  int          checked = 0;
  always #25 ref_clk = ~ref_clk;
  // Pull-ups win whenever nobody drives a line
  wire dout_w = dout_oe ? dout_out : 1'b1;
  wire din_w = (cs_n || din_oe) ? 1'b1 : h_din;
  sra_spi_regs #(.DEV_ADDR(BUS_ADDR)) u_dut (.ref_clk, .rst_n, .cs_n_pin(cs_n), .sclk_pin(sclk),
    .din_pin(din_w), .din_oe, .dout_out, .dout_oe, .limits, .conv_done, .limit_mask, .ara_ack,
    .ara_byte, .alert_out, .alert_oe, .spi_locked);
  sra_host u_host (.cs_n, .sclk, .din(h_din), .dout_w);
  // -----
  // Tasks
  // -----
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t byte %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_host.frame({`SRA_CMD_WRITE, 2'h0, a, d, 8'h00}, 3, rx);
  endtask
  // Point, then read two bytes in one frame
  task automatic rd2(input logic [5:0] a);
    u_host.frame({`SRA_CMD_WRITE, 2'h0, a, 16'h0}, 2, rx);
    u_host.frame({`SRA_CMD_READ, 24'h0}, 3, rx);
  endtask
  task automatic conv(input logic [5:0] l, input logic [5:0] m);
    @(negedge ref_clk);
    limits     = l;
    limit_mask = m;
    conv_done  = 1'b1;
    @(negedge ref_clk) conv_done = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  // ------------
  // Main sequence
  // ------------
  typedef struct packed {logic [5:0] a; logic [7:0] d0; logic [7:0] d1;} sra_row_s;
  sra_row_s rows [3] = '{'{6'h3E, 8'hA1, 8'hB2}, '{6'h20, 8'hC3, 8'h3C}, '{6'h30, 8'h5A, 8'hA5}};
  initial begin
    limits     = 6'h00;
    limit_mask = 6'h00;
    conv_done  = 1'b0;
    ara_ack    = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk1(dout_oe, 1'b0);
    chk1(alert_oe, 1'b0);
    chk8(ara_byte, 8'hFF);
    // Write before lock is dropped, and counts as the first pulse
    wr(`SRA_REG_CTRL, 8'h40);
    u_host.frame(32'h0, 0, rx);
    chk1(spi_locked, 1'b0);
    u_host.frame(32'h0, 0, rx);
    chk1(spi_locked, 1'b1);
    rd2(`SRA_REG_CTRL);
    chk8(rx[23:16], `SRA_CTRL_RESET);
    // Burst write then burst read of two neighbours
    foreach (rows[k]) begin
      u_host.frame({`SRA_CMD_WRITE, 2'h0, rows[k].a, rows[k].d0, rows[k].d1}, 4, rx);
      rd2(rows[k].a);
      chk8(rx[23:16], rows[k].d0);
      chk8(rx[15:8], rows[k].d1);
    end
    // Unknown command: the rest of the frame must not touch pointer or array
    u_host.frame({8'h55, 8'h20, 8'hFF, 8'h00}, 3, rx);
    rd2(6'h20);
    chk8(rx[23:16], 8'hC3);
    conv(6'b100000, 6'h00);
    chk1(alert_oe, 1'b1);
    @(negedge ref_clk) ara_ack = 1'b1;
    @(negedge ref_clk) chk8(ara_byte, {BUS_ADDR, 1'b1});
    ara_ack = 1'b0;
    // Line still low, so the master asks again and gets the same answer
    @(negedge ref_clk) ara_ack = 1'b1;
    @(negedge ref_clk) chk8(ara_byte, {BUS_ADDR, 1'b1});
    ara_ack = 1'b0;
    @(negedge ref_clk) chk8(ara_byte, 8'hFF);
    conv(6'h00, 6'h00);
    chk1(alert_oe, 1'b1);
    rd2(6'h3F);
    chk8(rx[23:16], 8'hB2);
    chk8(rx[15:8], 8'h08);
    conv(6'h00, 6'h00);
    chk1(alert_oe, 1'b0);
    // A device whose line is released stays silent at the response address
    @(negedge ref_clk) ara_ack = 1'b1;
    @(negedge ref_clk) chk8(ara_byte, 8'hFF);
    ara_ack = 1'b0;
    conv(6'b100000, 6'b100000);
    chk1(alert_oe, 1'b0);
    // Active high: the line is pulled while quiet and let go on an event
    wr(`SRA_REG_CTRL, 8'h40);
    chk1(alert_oe, 1'b1);
    conv(6'b000010, 6'h00);
    chk1(alert_oe, 1'b0);
    wr(`SRA_REG_CTRL, 8'h20);
    conv(6'b000010, 6'h00);
    chk1(alert_oe, 1'b0);
    rd2(`SRA_REG_CTRL);
    chk8(rx[23:16], 8'h20);
    rd2(`SRA_REG_STAT2);
    chk8(rx[23:16], 8'h02);
    // Enabling again shows the alert was held all along
    wr(`SRA_REG_CTRL, 8'h00);
    chk1(alert_oe, 1'b1);
    summarize();
  end
  // Whole run needs well under half a millisecond
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
endmodule
